//--- converter_consts.vh
// Operation
// - Right justify zeroes high byte upper six
// - Left justify zeroes low byte lower six
// - Codes 111 and 011 pick RC clock
// - Bit 2 picks external pin or ground
// - Positive reference 11 FIXED_VOLTAGE_REFERENCE, 10 pin, 00 supply
// - Left mode high byte holds bits 9..2
// - Left mode low byte bits 7..6 hold 1..0
// - Right mode high byte bits 1..0 hold 9..8
// - Right mode low byte holds bits 7..0
// - Result bytes writable, kept over soft reset
`ifndef CONVERTER_CONSTS_VH
`define CONVERTER_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define CONFIG_OFFSET       4'h0
`define RESULT_HIGH_OFFSET  4'h4
`define RESULT_LOW_OFFSET   4'h8
`define CONFIG_RESET        8'h00
`define CONFIG_WMASK        8'hf7

// ****************************************************************
// Field positions
// ****************************************************************
`define JUSTIFY_BIT         7
`define CLKSEL_HI           6
`define CLKSEL_LO           4
`define NEGREF_BIT          2
`define POSREF_HI           1
`define POSREF_LO           0

// ****************************************************************
// Encodings
// ****************************************************************
`define CLKSEL_RC_A         3'h7
`define CLKSEL_RC_B         3'h3
`define POSREF_SUPPLY       2'h0
`define POSREF_RESERVED     2'h1
`define POSREF_PIN          2'h2
`define POSREF_FIXED        2'h3
`define DIV_2               7'h02
`define DIV_4               7'h04
`define DIV_8               7'h08
`define DIV_16              7'h10
`define DIV_32              7'h20
`define DIV_64              7'h40

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

//--- conversion_clock_gen.v
`timescale 1ns/1ps
`include "converter_consts.vh"

// Produces a one-cycle enable per conversion clock period
module conversion_clock_gen (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire [2:0] conversion_clock_select,
   input  wire       rc_tick,
   output reg        conv_tick,
   output reg        rc_selected
);

   reg  [6:0] div_count;
   reg  [6:0] ratio;
   wire       use_rc;

   // ****************************************************************
   // Divisor table
   // ****************************************************************
   // Ratios assumed as a power-of-two ladder; change here if they differ
   always @* begin
      case (conversion_clock_select)
         3'h0:    ratio = `DIV_2;
         3'h1:    ratio = `DIV_8;
         3'h2:    ratio = `DIV_32;
         3'h4:    ratio = `DIV_4;
         3'h5:    ratio = `DIV_16;
         3'h6:    ratio = `DIV_64;
         default: ratio = `DIV_2;
      endcase
   end

   assign use_rc = (conversion_clock_select == `CLKSEL_RC_A) ||
                   (conversion_clock_select == `CLKSEL_RC_B);

   always @(posedge aclk) begin
      if (!aresetn) begin
         div_count   <= 7'h00;
         conv_tick   <= 1'b0;
         rc_selected <= 1'b0;
      end else begin
         rc_selected <= use_rc;
         if (use_rc) begin
            div_count <= 7'h00;
            conv_tick <= rc_tick;
         end else if (div_count >= ratio - 7'h01) begin
            div_count <= 7'h00;
            conv_tick <= 1'b1;
         end else begin
            div_count <= div_count + 7'h01;
            conv_tick <= 1'b0;
         end
      end
   end

endmodule

//--- converter_format.v
`timescale 1ns/1ps
`include "converter_consts.vh"

// Converter configuration and result formatting, AXI4-Lite slave
module converter_format (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        por_n,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [9:0]  conversion_result_value,
   input  wire        conversion_done,
   input  wire        rc_tick,
   output wire        conv_tick,
   output wire        rc_selected,
   output wire        negative_reference_select,
   output wire [1:0]  positive_reference_select,
   output reg         neg_ref_external,
   output reg         pos_ref_supply,
   output reg         pos_ref_pin,
   output reg         pos_ref_fixed
);

   reg  [7:0]  converter_config_reg;
   reg  [7:0]  result_high_byte;
   reg  [7:0]  result_low_byte;
   reg  [3:0]  aw_addr;
   reg         aw_held;
   reg  [31:0] w_data;
   reg         w_byte0;
   reg         w_held;
   wire        do_write;
   wire        result_justify_select;
   wire [2:0]  conversion_clock_select;
   wire [15:0] formatted;

   // ****************************************************************
   // Formatting
   // ****************************************************************
   // Returns {high, low}; reserved bits come out as zero
   function [15:0] pack_result;
      input       right;
      input [9:0] value;
      begin
         if (right)
            pack_result = {6'h00, value[9:8], value[7:0]};
         else
            pack_result = {value[9:2], value[1:0], 6'h00};
      end
   endfunction

   function mapped;
      input [3:0] addr;
      begin
         mapped = (addr == `CONFIG_OFFSET) ||
                  (addr == `RESULT_HIGH_OFFSET) ||
                  (addr == `RESULT_LOW_OFFSET);
      end
   endfunction

   assign result_justify_select   = converter_config_reg[`JUSTIFY_BIT];
   assign conversion_clock_select =
      converter_config_reg[`CLKSEL_HI:`CLKSEL_LO];
   assign negative_reference_select = converter_config_reg[`NEGREF_BIT];
   assign positive_reference_select =
      converter_config_reg[`POSREF_HI:`POSREF_LO];
   // Justify chosen at load time, both bytes from one value
   assign formatted = pack_result(result_justify_select,
                                  conversion_result_value);

   // ****************************************************************
   // Write channel
   // ****************************************************************
   // Address and data are latched separately so either may come first
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 4'h0;
         w_data       <= 32'h00000000;
         w_byte0      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_byte0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Configuration register
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn)
         converter_config_reg <= `CONFIG_RESET;
      else if (do_write && w_byte0 && aw_addr == `CONFIG_OFFSET)
         converter_config_reg <= w_data[7:0] & `CONFIG_WMASK;
   end

   // ****************************************************************
   // Result bytes
   // ****************************************************************
   // Only power-on reset touches them; soft reset leaves them alone.
   // Values after power-on are undefined, zero is chosen here.
   always @(posedge aclk) begin
      if (!por_n) begin
         result_high_byte <= 8'h00;
         result_low_byte  <= 8'h00;
      end else if (conversion_done) begin
         // Conversion wins over a same-cycle software write
         result_high_byte <= formatted[15:8];
         result_low_byte  <= formatted[7:0];
      end else if (do_write && w_byte0) begin
         if (aw_addr == `RESULT_HIGH_OFFSET)
            result_high_byte <= w_data[7:0];
         if (aw_addr == `RESULT_LOW_OFFSET)
            result_low_byte  <= w_data[7:0];
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY
                                              : `RESP_SLVERR;
         case (s_axi_araddr)
            `CONFIG_OFFSET:
               s_axi_rdata <= {24'h000000, converter_config_reg};
            `RESULT_HIGH_OFFSET:
               s_axi_rdata <= {24'h000000, result_high_byte};
            `RESULT_LOW_OFFSET:
               s_axi_rdata <= {24'h000000, result_low_byte};
            default:
               s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // Reference routing
   // ****************************************************************
   // Reserved positive code drives no source rather than guessing one
   always @(posedge aclk) begin
      if (!aresetn) begin
         neg_ref_external <= 1'b0;
         pos_ref_supply   <= 1'b1;
         pos_ref_pin      <= 1'b0;
         pos_ref_fixed    <= 1'b0;
      end else begin
         neg_ref_external <= negative_reference_select;
         pos_ref_supply   <= positive_reference_select
                             == `POSREF_SUPPLY;
         pos_ref_pin      <= positive_reference_select
                             == `POSREF_PIN;
         pos_ref_fixed    <= positive_reference_select
                             == `POSREF_FIXED;
      end
   end

   // ****************************************************************
   // Conversion clock
   // ****************************************************************
   conversion_clock_gen clock_gen (
      .aclk                    (aclk),
      .aresetn                 (aresetn),
      .conversion_clock_select (conversion_clock_select),
      .rc_tick                 (rc_tick),
      .conv_tick               (conv_tick),
      .rc_selected             (rc_selected)
   );

endmodule

//--- converter_format_monitor.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker
// ****************************************************************
module converter_format_monitor (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awready,
   input wire        s_axi_bvalid,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   input wire        conversion_done,
   input wire        rc_tick,
   input wire        conv_tick,
   input wire        rc_selected,
   input wire        negative_reference_select,
   input wire [1:0]  positive_reference_select,
   input wire        neg_ref_external,
   input wire        pos_ref_supply,
   input wire        pos_ref_pin,
   input wire        pos_ref_fixed
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Decode lags the select by one cycle, so skip the edge out of reset
   ref_neg_a: assert property ($past(aresetn) |-> neg_ref_external == $past(negative_reference_select)) else $error("neg ref decode");
   ref_fixed_a: assert property ($past(aresetn) |-> pos_ref_fixed == ($past(positive_reference_select) == 2'h3)) else $error("fixed ref decode");
   ref_pin_a: assert property ($past(aresetn) |-> pos_ref_pin == ($past(positive_reference_select) == 2'h2)) else $error("pin ref decode");
   ref_supply_a: assert property ($past(aresetn) |-> pos_ref_supply == ($past(positive_reference_select) == 2'h0)) else $error("supply ref decode");
   rc_pass_a: assert property (rc_selected && $past(rc_selected) |-> conv_tick == $past(rc_tick)) else $error("rc tick not passed");
   read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");
   read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
   cover property (conversion_done);
   cover property (rc_selected && conv_tick);
   cover property (pos_ref_fixed && neg_ref_external);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

//--- adc_config_and_result_format_tb.sv
`timescale 1ns/1ps
`include "converter_consts.vh"
// ****************************************************************
// Bench
// ****************************************************************
module adc_config_and_result_format_tb;
   reg         aclk, aresetn, por_n, rc_tick, conversion_done;
   reg         s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
   reg         s_axi_bready, s_axi_rready;
   reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   reg  [31:0] s_axi_wdata;
   reg  [9:0]  conversion_result_value;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire        s_axi_rvalid, conv_tick, rc_selected;
   wire        negative_reference_select, neg_ref_external;
   wire        pos_ref_supply, pos_ref_pin, pos_ref_fixed;
   wire [1:0]  s_axi_bresp, s_axi_rresp, positive_reference_select;
   wire [31:0] s_axi_rdata;
   integer     mismatches, checks_done, i, n_ticks;
   reg  [31:0] rd;
   reg  [1:0]  rs;
   reg  [9:0]  v;
   converter_format uut (.*);
   task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Ready inputs stay high, so each wait ends on the answer's edge
   task wr(input [3:0] a, input [7:0] d);
      integer n;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h0, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         for (n = 0; n < 100; n = n + 1) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
               rs = s_axi_bresp;
               n = 100;
            end
         end
      end
   endtask
   task rdr(input [3:0] a);
      integer n;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         for (n = 0; n < 100; n = n + 1) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
               rd = s_axi_rdata;
               rs = s_axi_rresp;
               n = 100;
            end
         end
      end
   endtask
   task conv(input [9:0] val);
      begin
         conversion_result_value <= val;
         conversion_done <= 1'b1;
         @(posedge aclk);
         conversion_done <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task t_reset;
      begin
         rdr(`CONFIG_OFFSET);
         chk("config", {24'h0, `CONFIG_RESET}, rd);
         chk("supply", {31'h0, pos_ref_supply}, 32'h1);
         rdr(`RESULT_HIGH_OFFSET);
         chk("res_hi", 32'h0, rd);
         $display("test reset done");
      end
   endtask
   task t_justify;
      for (i = 0; i < 4; i = i + 1) begin
         v = i[1] ? 10'h3ff : 10'h2b5;
         wr(`CONFIG_OFFSET, {i[0], 7'h00});
         conv(v);
         rdr(`RESULT_HIGH_OFFSET);
         chk("res_hi", i[0] ? {30'h0, v[9:8]} : {24'h0, v[9:2]}, rd);
         rdr(`RESULT_LOW_OFFSET);
         chk("res_lo", i[0] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0}, rd);
      end
      // Justify change after the load must not reformat the stored bytes
      wr(`CONFIG_OFFSET, 8'h00);
      rdr(`RESULT_HIGH_OFFSET);
      chk("res_hi", 32'h3, rd);
      $display("test justify done");
   endtask
   task t_refs;
      for (i = 0; i < 8; i = i + 1) begin
         wr(`CONFIG_OFFSET, {5'h0, i[2:0]});
         @(posedge aclk);
         chk("neg", {31'h0, neg_ref_external}, {31'h0, i[2]});
         chk("fixed", {31'h0, pos_ref_fixed}, i[1:0] == 2'h3);
         chk("pin", {31'h0, pos_ref_pin}, i[1:0] == 2'h2);
         chk("supply", {31'h0, pos_ref_supply}, i[1:0] == 2'h0);
      end
      wr(`CONFIG_OFFSET, 8'hff);
      rdr(`CONFIG_OFFSET);
      chk("config", {24'h0, `CONFIG_WMASK}, rd);
      $display("test refs done");
   endtask
   // Ticks seen in a 128-cycle window; one RC pulse is sent per window
   function integer exp_ticks(input [2:0] c);
      case (c)
         3'h0:    exp_ticks = 128 / `DIV_2;
         3'h1:    exp_ticks = 128 / `DIV_8;
         3'h2:    exp_ticks = 128 / `DIV_32;
         3'h4:    exp_ticks = 128 / `DIV_4;
         3'h5:    exp_ticks = 128 / `DIV_16;
         3'h6:    exp_ticks = 128 / `DIV_64;
         default: exp_ticks = 1;
      endcase
   endfunction
   task t_clock;
      for (i = 0; i < 8; i = i + 1) begin
         wr(`CONFIG_OFFSET, {1'b0, i[2:0], 4'h0});
         repeat (2) @(posedge aclk);
         chk("rc_sel", {31'h0, rc_selected}, i[1:0] == 2'h3);
         n_ticks = 0;
         rc_tick <= 1'b1;
         @(posedge aclk);
         rc_tick <= 1'b0;
         repeat (128) begin
            @(posedge aclk);
            if (conv_tick === 1'b1) n_ticks = n_ticks + 1;
         end
         chk("ticks", exp_ticks(i[2:0]), n_ticks);
      end
      $display("test clock done");
   endtask
   task t_keep;
      begin
         wr(`RESULT_HIGH_OFFSET, 8'ha5);
         wr(`RESULT_LOW_OFFSET, 8'h5a);
         aresetn <= 1'b0;
         @(posedge aclk);
         aresetn <= 1'b1;
         @(posedge aclk);
         rdr(`RESULT_HIGH_OFFSET);
         chk("res_hi", 32'ha5, rd);
         rdr(`RESULT_LOW_OFFSET);
         chk("res_lo", 32'h5a, rd);
         por_n <= 1'b0;
         @(posedge aclk);
         por_n <= 1'b1;
         @(posedge aclk);
         rdr(`RESULT_LOW_OFFSET);
         chk("res_lo", 32'h0, rd);
         rdr(4'hc);
         chk("rresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
         chk("rdata", 32'h0, rd);
         wr(4'hc, 8'h11);
         chk("bresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
         $display("test keep done");
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      print_verdict;
   end
   initial begin
      {mismatches, checks_done, aresetn, por_n, rc_tick} = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, conversion_done} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      conversion_result_value = 10'h000;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_justify;
      t_refs;
      t_clock;
      t_keep;
      print_verdict;
   end
endmodule
bind converter_format converter_format_monitor mon (.*);
